// ---- inc/dtr_pkg.sv ----
// Constants, register map and state type of the display text registration engine.
package dtr_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 8;
	localparam int BYTE_W = 8;
	localparam int STR_WORDS = 16;
	localparam int DEST_WORDS = 8;
	localparam int SRC_WORDS = 9;
	localparam int NAME_WORDS = 8;
	localparam int MON_CNT = 3;
	localparam int ERRN_CNT = 5;
	localparam int IRQ_W = 3;
	localparam logic [5:0] STR_MAX_CHARS = 6'h10;
	localparam logic [5:0] STR_LIMIT = 6'h20;
	// ****************************************************************
	// Register map.
	// ****************************************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STRLEN = 8'h01;
	localparam logic [7:0] ADDR_STATUS = 8'h02;
	localparam logic [7:0] ADDR_ERRCODE = 8'h03;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h05;
	localparam logic [7:0] ADDR_USER_ERR = 8'h06;
	localparam logic [7:0] ADDR_VALID = 8'h07;
	localparam logic [7:0] STR_BASE = 8'h10;
	localparam logic [7:0] DEST_BASE = 8'h20;
	localparam logic [7:0] SRC_BASE = 8'h30;
	localparam logic [7:0] MON_BASE = 8'h40;
	localparam logic [7:0] ERRN_BASE = 8'h60;
	// ****************************************************************
	// Field positions and codes.
	// ****************************************************************
	localparam int CTRL_GO_STR = 0;
	localparam int CTRL_GO_REG = 1;
	localparam int CTRL_SRC_DEV = 2;
	localparam int CTRL_DST_BIT = 3;
	localparam int STAT_ERR = 0;
	localparam int STAT_UERR = 1;
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_UERR = 1;
	localparam int IRQ_DONE = 2;
	localparam int VALID_ERRN_LSB = 8;
	localparam logic [15:0] ERR_INSTR = 16'h0fa0;
	localparam logic [15:0] ERR_OPER = 16'h1004;
	localparam logic [7:0] KIND_MON = 8'h01;
	localparam logic [7:0] KIND_ERRN = 8'h02;
	localparam logic [7:0] KIND_MON_CLR = 8'h81;
	localparam logic [7:0] KIND_ERRN_CLR = 8'h82;
	localparam logic [7:0] MON_FIRST = 8'h28;
	localparam logic [7:0] MON_LAST = 8'h2a;
	localparam logic [7:0] ERRN_FIRST = 8'h10;
	localparam logic [7:0] ERRN_LAST = 8'h14;
	localparam logic [15:0] UERR_FIRST = 16'h0010;
	localparam logic [15:0] UERR_LAST = 16'h0014;
	localparam logic [15:0] WORD_ZERO = 16'h0000;

	typedef struct packed {
		logic [15:0] rdData;
		logic irq;
		logic errFlag;
		logic [15:0] errCode;
		logic [2:0] irqStat;
		logic [2:0] irqMask;
		logic [5:0] strLen;
		logic [15:0][15:0] strBuf;
		logic [7:0][15:0] destWords;
		logic [8:0][15:0] srcWords;
		logic [15:0] userErrCode;
		logic userErrActive;
		logic [2:0] monValid;
		logic [4:0] errnValid;
		logic [2:0][7:0][15:0] monNames;
		logic [4:0][7:0][15:0] errNames;
	} dtr_state_t;
endpackage

// ---- src/dtr_text_engine.sv ----
// Display text registration engine: string transfer and panel name registration.
`timescale 1ns/1ps
module dtr_text_engine import dtr_pkg::*; (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Register port.
	input wire logic [7:0] addr,
	input wire logic [15:0] wrData,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	output logic [15:0] rdData,
	// Status towards the system and the panel.
	output logic irq,
	output logic errorFlag,
	output logic userErrorActive,
	output logic [2:0] monNameValid,
	output logic [4:0] errNameValid
);
	dtr_state_t s;
	dtr_state_t n;
	logic wrCtrl;
	logic goStr;
	logic goReg;
	logic [7:0] kindByte;
	logic [7:0] selByte;
	logic [7:0] monIdx;
	logic [7:0] errIdx;
	logic [7:0] offs;
	logic [7:0][15:0] srcName;
	logic [2:0] irqEvent;

	assign wrCtrl = wrStrobe && (addr == ADDR_CTRL);
	assign goStr = wrCtrl && wrData[CTRL_GO_STR];
	// A combined write runs only the string transfer.
	assign goReg = wrCtrl && wrData[CTRL_GO_REG] && !wrData[CTRL_GO_STR];
	assign kindByte = s.srcWords[0][7:0];
	assign selByte = s.srcWords[0][15:8];
	assign monIdx = selByte - MON_FIRST;
	assign errIdx = selByte - ERRN_FIRST;
	assign srcName = s.srcWords[8:1];

	// ****************************************************************
	// Next state.
	// ****************************************************************
	always_comb begin
		n = s;
		irqEvent = '0;
		offs = 8'h00;
		n.rdData = WORD_ZERO;
		// Register writes.
		if (wrStrobe) begin
			unique case (1'b1)
				// The whole word is compared, so a large count never wraps to a short one.
				addr == ADDR_STRLEN: n.strLen = (wrData > 16'(STR_LIMIT)) ? STR_LIMIT : wrData[5:0];
				addr == ADDR_STATUS: begin
					if (wrData[STAT_ERR]) begin
						n.errFlag = 1'b0;
					end
				end
				addr == ADDR_IRQ_MASK: n.irqMask = wrData[IRQ_W-1:0];
				addr == ADDR_USER_ERR: begin
					n.userErrCode = wrData;
					n.userErrActive = (wrData >= UERR_FIRST) && (wrData <= UERR_LAST);
					irqEvent[IRQ_UERR] = n.userErrActive;
				end
				addr[7:4] == STR_BASE[7:4]: n.strBuf[addr[3:0]] = wrData;
				(addr >= SRC_BASE) && (addr < SRC_BASE + 8'(SRC_WORDS)): begin
					offs = addr - SRC_BASE;
					n.srcWords[offs[3:0]] = wrData;
				end
				default: begin
				end
			endcase
		end
		// String transfer into the destination words.
		if (goStr) begin
			if (wrData[CTRL_SRC_DEV] || wrData[CTRL_DST_BIT]) begin
				n.errFlag = 1'b1;
				n.errCode = ERR_INSTR;
				irqEvent[IRQ_FAULT] = 1'b1;
			end else begin
				for (int i = 0; i < 2 * DEST_WORDS; i++) begin
					// Characters past the sixteenth never land; short strings touch only their bytes.
					if (6'(i) < s.strLen) begin
						n.destWords[i / 2][(i % 2) * BYTE_W +: BYTE_W] =
							s.strBuf[i / 2][(i % 2) * BYTE_W +: BYTE_W];
					end
				end
				irqEvent[IRQ_DONE] = 1'b1;
			end
		end
		// Panel name registration. The unused module and output operands never reach here.
		if (goReg) begin
			unique case (kindByte)
				KIND_MON, KIND_MON_CLR: begin
					if (selByte >= MON_FIRST && selByte <= MON_LAST) begin
						if (kindByte == KIND_MON) begin
							n.monNames[monIdx[1:0]] = srcName;
							n.monValid[monIdx[1:0]] = 1'b1;
						end else begin
							n.monNames[monIdx[1:0]] = '0;
							n.monValid[monIdx[1:0]] = 1'b0;
						end
						irqEvent[IRQ_DONE] = 1'b1;
					end else begin
						n.errFlag = 1'b1;
						n.errCode = ERR_OPER;
						irqEvent[IRQ_FAULT] = 1'b1;
					end
				end
				KIND_ERRN, KIND_ERRN_CLR: begin
					if (selByte >= ERRN_FIRST && selByte <= ERRN_LAST) begin
						if (kindByte == KIND_ERRN) begin
							n.errNames[errIdx[2:0]] = srcName;
							n.errnValid[errIdx[2:0]] = 1'b1;
						end else begin
							n.errNames[errIdx[2:0]] = '0;
							n.errnValid[errIdx[2:0]] = 1'b0;
						end
						irqEvent[IRQ_DONE] = 1'b1;
					end else begin
						n.errFlag = 1'b1;
						n.errCode = ERR_OPER;
						irqEvent[IRQ_FAULT] = 1'b1;
					end
				end
				default: begin
					// Unknown text kinds are operation faults; stored text stays put.
					n.errFlag = 1'b1;
					n.errCode = ERR_OPER;
					irqEvent[IRQ_FAULT] = 1'b1;
				end
			endcase
		end
		// Sticky interrupt bits: a new event beats a simultaneous write-one clear.
		if (wrStrobe && addr == ADDR_IRQ_STAT) begin
			n.irqStat = s.irqStat & ~wrData[IRQ_W-1:0];
		end
		n.irqStat = n.irqStat | irqEvent;
		n.irq = |(n.irqStat & n.irqMask);
		// Read port: data stands in the cycle after the strobe only.
		if (rdStrobe) begin
			unique case (1'b1)
				addr == ADDR_CTRL: n.rdData = WORD_ZERO;
				addr == ADDR_STRLEN: n.rdData = {10'h000, s.strLen};
				addr == ADDR_STATUS: n.rdData = {14'h0000, s.userErrActive, s.errFlag};
				addr == ADDR_ERRCODE: n.rdData = s.errCode;
				addr == ADDR_IRQ_STAT: n.rdData = {13'h0000, s.irqStat};
				addr == ADDR_IRQ_MASK: n.rdData = {13'h0000, s.irqMask};
				addr == ADDR_USER_ERR: n.rdData = s.userErrCode;
				addr == ADDR_VALID: n.rdData = {3'h0, s.errnValid, 5'h00, s.monValid};
				addr[7:4] == STR_BASE[7:4]: n.rdData = s.strBuf[addr[3:0]];
				addr[7:3] == DEST_BASE[7:3]: n.rdData = s.destWords[addr[2:0]];
				(addr >= SRC_BASE) && (addr < SRC_BASE + 8'(SRC_WORDS)): begin
					offs = addr - SRC_BASE;
					n.rdData = s.srcWords[offs[3:0]];
				end
				(addr >= MON_BASE) && (addr < MON_BASE + 8'(MON_CNT * NAME_WORDS)): begin
					offs = addr - MON_BASE;
					n.rdData = s.monNames[offs[4:3]][offs[2:0]];
				end
				(addr >= ERRN_BASE) && (addr < ERRN_BASE + 8'(ERRN_CNT * NAME_WORDS)): begin
					offs = addr - ERRN_BASE;
					n.rdData = s.errNames[offs[5:3]][offs[2:0]];
				end
				default: n.rdData = WORD_ZERO;
			endcase
		end
	end

	// ****************************************************************
	// State register.
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign rdData = s.rdData;
	assign irq = s.irq;
	assign errorFlag = s.errFlag;
	assign userErrorActive = s.userErrActive;
	assign monNameValid = s.monValid;
	assign errNameValid = s.errnValid;

	// ****************************************************************
	// Checks.
	// ****************************************************************
	AST_SRC_DEVICE: assert property (@(posedge clk) disable iff (reset)
		goStr && wrData[CTRL_SRC_DEV] |=> errorFlag && s.errCode == ERR_INSTR)
		else $error("Device source did not raise the instruction fault.");

	AST_DST_BIT: assert property (@(posedge clk) disable iff (reset)
		goStr && wrData[CTRL_DST_BIT] && !wrData[CTRL_SRC_DEV]
		|=> errorFlag && s.errCode == ERR_INSTR && $stable(s.destWords))
		else $error("Bit destination was not refused.");

	AST_TRUNCATE: assert property (@(posedge clk) disable iff (reset)
		goStr && !wrData[CTRL_SRC_DEV] && !wrData[CTRL_DST_BIT] && s.strLen > STR_MAX_CHARS
		|=> s.destWords == $past(s.strBuf[7:0]))
		else $error("Long string did not deliver exactly sixteen characters.");

	AST_SHORT_KEEP: assert property (@(posedge clk) disable iff (reset)
		goStr && !wrData[CTRL_SRC_DEV] && !wrData[CTRL_DST_BIT] && s.strLen == 6'h01
		|=> s.destWords[7:1] == $past(s.destWords[7:1])
			&& s.destWords[0][15:8] == $past(s.destWords[0][15:8]))
		else $error("Short string disturbed untouched destination bytes.");

	AST_MON_MAP: assert property (@(posedge clk) disable iff (reset)
		goReg && kindByte == KIND_MON && selByte == MON_LAST
		|=> monNameValid[2] && s.monNames[2] == $past(srcName))
		else $error("Monitor description number did not map to its monitor.");

	AST_MON_RANGE: assert property (@(posedge clk) disable iff (reset)
		goReg && kindByte == KIND_MON && (selByte < MON_FIRST || selByte > MON_LAST)
		|=> errorFlag && s.errCode == ERR_OPER && $stable(s.monNames))
		else $error("Bad monitor number did not raise the operation fault.");

	AST_MON_ERASE: assert property (@(posedge clk) disable iff (reset)
		goReg && kindByte == KIND_MON_CLR && selByte >= MON_FIRST && selByte <= MON_LAST
		|=> !monNameValid[$past(monIdx[1:0])] && s.monNames[$past(monIdx[1:0])] == '0)
		else $error("Monitor name was not erased.");

	AST_ERRN_RANGE: assert property (@(posedge clk) disable iff (reset)
		goReg && kindByte == KIND_ERRN && (selByte < ERRN_FIRST || selByte > ERRN_LAST)
		|=> errorFlag && s.errCode == ERR_OPER && $stable(errNameValid))
		else $error("Bad error number did not raise the operation fault.");

	AST_ERRN_CLEAR: assert property (@(posedge clk) disable iff (reset)
		goReg && kindByte == KIND_ERRN_CLR && selByte >= ERRN_FIRST && selByte <= ERRN_LAST
		|=> !errNameValid[$past(errIdx[2:0])] && s.errNames[$past(errIdx[2:0])] == '0)
		else $error("Error name was not cleared.");

	AST_USER_ERR: assert property (@(posedge clk) disable iff (reset)
		wrStrobe && addr == ADDR_USER_ERR && wrData >= UERR_FIRST && wrData <= UERR_LAST
		|=> userErrorActive && s.irqStat[IRQ_UERR])
		else $error("User error code in range did not trigger.");

	AST_FAULT_KEEPS_TEXT: assert property (@(posedge clk) disable iff (reset)
		goReg && kindByte != KIND_MON && kindByte != KIND_MON_CLR
			&& kindByte != KIND_ERRN && kindByte != KIND_ERRN_CLR
		|=> errorFlag && $stable(s.monNames) && $stable(s.errNames))
		else $error("Unknown text kind changed registered text.");

	AST_READ_ONE_CYCLE: assert property (@(posedge clk) disable iff (reset)
		!rdStrobe |=> rdData == WORD_ZERO)
		else $error("Read data stood beyond its cycle.");

	AST_MON_STORE: assert property (@(posedge clk) disable iff (reset)
		goReg && kindByte == KIND_MON && selByte >= MON_FIRST && selByte <= MON_LAST
		|=> monNameValid[$past(monIdx[1:0])]
			&& s.monNames[$past(monIdx[1:0])] == $past(srcName))
		else $error("Monitor name was not stored in its slot.");

	AST_ERRN_STORE: assert property (@(posedge clk) disable iff (reset)
		goReg && kindByte == KIND_ERRN && selByte >= ERRN_FIRST && selByte <= ERRN_LAST
		|=> errNameValid[$past(errIdx[2:0])]
			&& s.errNames[$past(errIdx[2:0])] == $past(srcName))
		else $error("Error name was not stored in its slot.");

	AST_USER_ERR_IDLE: assert property (@(posedge clk) disable iff (reset)
		wrStrobe && addr == ADDR_USER_ERR && (wrData < UERR_FIRST || wrData > UERR_LAST)
		|=> !userErrorActive)
		else $error("User error code out of range still triggered.");

	AST_STR_FAULT_KEEPS: assert property (@(posedge clk) disable iff (reset)
		goStr && (wrData[CTRL_SRC_DEV] || wrData[CTRL_DST_BIT])
		|=> $stable(s.destWords) && $stable(s.monNames) && $stable(s.errNames))
		else $error("Refused string transfer changed stored text.");

	AST_FAULT_IRQ: assert property (@(posedge clk) disable iff (reset)
		$rose(errorFlag) |-> s.irqStat[IRQ_FAULT])
		else $error("Fault did not set its interrupt bit.");

	AST_STR_DONE: assert property (@(posedge clk) disable iff (reset)
		goStr && !wrData[CTRL_SRC_DEV] && !wrData[CTRL_DST_BIT]
		|=> s.irqStat[IRQ_DONE])
		else $error("Finished string transfer did not set its interrupt bit.");

	AST_ERR_CLEAR: assert property (@(posedge clk) disable iff (reset)
		wrStrobe && addr == ADDR_STATUS && wrData[STAT_ERR]
		|=> !errorFlag)
		else $error("Error flag did not clear on a write of one.");

	AST_SHORT_FILL: assert property (@(posedge clk) disable iff (reset)
		goStr && !wrData[CTRL_SRC_DEV] && !wrData[CTRL_DST_BIT] && s.strLen == 6'h03
		|=> s.destWords[0] == $past(s.strBuf[0])
			&& s.destWords[1][7:0] == $past(s.strBuf[1][7:0])
			&& s.destWords[1][15:8] == $past(s.destWords[1][15:8]))
		else $error("Three character string did not land byte by byte.");

	AST_STRLEN_CLAMP: assert property (@(posedge clk) disable iff (reset)
		wrStrobe && addr == ADDR_STRLEN && wrData > 16'(STR_LIMIT)
		|=> s.strLen == STR_LIMIT)
		else $error("Oversized string length was not clamped.");

	AST_READ_ERRCODE: assert property (@(posedge clk) disable iff (reset)
		rdStrobe && addr == ADDR_ERRCODE
		|=> rdData == $past(s.errCode))
		else $error("Error code read returned another value.");

	AST_READ_VALID: assert property (@(posedge clk) disable iff (reset)
		rdStrobe && addr == ADDR_VALID
		|=> rdData[VALID_ERRN_LSB +: ERRN_CNT] == $past(errNameValid))
		else $error("Valid read did not show the error name slots.");
endmodule

// ---- test/dtr_program_model.sv ----
// Sequence program model that drives the engine's register port.
`timescale 1ns/1ps
module dtr_program_model import dtr_pkg::*; (
	// Clock.
	input wire logic clk,
	// Register port.
	output logic [7:0] addr,
	output logic [15:0] wrData,
	output logic wrStrobe,
	output logic rdStrobe,
	input wire logic [15:0] rdData
);
	initial begin
		addr = 8'h00;
		wrData = 16'h0000;
		wrStrobe = 1'b0;
		rdStrobe = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		wrStrobe <= 1'b1;
		@(posedge clk);
		wrStrobe <= 1'b0;
		// Released data is inverted so a stale value is never mistaken for a fresh one.
		wrData <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rdStrobe <= 1'b1;
		@(posedge clk);
		rdStrobe <= 1'b0;
		@(posedge clk);
		d = rdData;
	endtask
	function automatic logic [15:0] chars(input logic [7:0] t, input int j);
		return {t, 8'h30 + 8'(j)};
	endfunction
	task automatic name(input logic [7:0] kind, input logic [7:0] num, input logic [7:0] t);
		wr(SRC_BASE, {num, kind});
		for (int j = 0; j < 8; j++) begin
			wr(SRC_BASE + 8'(j + 1), chars(t, j));
		end
		// The unused operands carry no bits of their own in the command word.
		wr(ADDR_CTRL, 16'h0002);
	endtask
endmodule

// ---- test/dtr_text_engine_test.sv ----
// Self-checking bench for the display text registration engine.
`timescale 1ns/1ps
module dtr_text_engine_test import dtr_pkg::*;;
	logic clk;
	logic reset;
	logic [7:0] addr;
	logic [15:0] wrData;
	logic wrStrobe;
	logic rdStrobe;
	logic [15:0] rdData;
	logic irq;
	logic errorFlag;
	logic userErrorActive;
	logic [2:0] monNameValid;
	logic [4:0] errNameValid;
	logic [15:0] ue [4] = '{16'h000f, 16'h0010, 16'h0014, 16'h0015};
	int errCount = 0;
	int checks = 0;

	dtr_text_engine dut (.clk(clk), .reset(reset), .addr(addr), .wrData(wrData),
		.wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .irq(irq),
		.errorFlag(errorFlag), .userErrorActive(userErrorActive),
		.monNameValid(monNameValid), .errNameValid(errNameValid));
	dtr_program_model prog (.clk(clk), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
		.rdStrobe(rdStrobe), .rdData(rdData));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			errCount++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] d;
		prog.rd(a, d);
		chk(d, exp);
	endtask
	// Two edges let a write land and the registered outputs follow it.
	task automatic idle();
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic fault(input logic [15:0] code);
		idle();
		chk(16'(errorFlag), 16'h0001);
		rc(ADDR_ERRCODE, code);
		prog.wr(ADDR_STATUS, 16'h0001);
		prog.wr(ADDR_IRQ_STAT, 16'h0007);
		idle();
		chk(16'(errorFlag), 16'h0000);
	endtask
	task automatic end_sim();
		$display("Mismatches %0d, comparisons %0d", errCount, checks);
		if (errCount == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		errCount++;
		$display("wrong value at %0t: run did not finish", $time);
		end_sim();
	end
	initial begin
		reset = 1'b1;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		rc(ADDR_ERRCODE, WORD_ZERO);
		prog.wr(ADDR_IRQ_MASK, 16'h0007);
		for (int i = 0; i < 16; i++) begin
			prog.wr(STR_BASE + 8'(i), 16'ha000 + 16'(i));
		end
		prog.wr(ADDR_STRLEN, 16'h0040);
		rc(ADDR_STRLEN, 16'h0020);
		prog.wr(ADDR_CTRL, 16'h0001);
		idle();
		chk(16'(irq), 16'h0001);
		for (int i = 0; i < 8; i++) begin
			rc(DEST_BASE + 8'(i), 16'ha000 + 16'(i));
		end
		rc(ADDR_IRQ_STAT, 16'h0004);
		prog.wr(ADDR_IRQ_STAT, 16'h0004);
		idle();
		chk(16'(irq), 16'h0000);
		prog.wr(STR_BASE, 16'h1111);
		prog.wr(STR_BASE + 8'h01, 16'h2222);
		prog.wr(ADDR_STRLEN, 16'h0003);
		prog.wr(ADDR_CTRL, 16'h0001);
		rc(DEST_BASE, 16'h1111);
		rc(DEST_BASE + 8'h01, 16'ha022);
		rc(DEST_BASE + 8'h02, 16'ha002);
		prog.wr(STR_BASE, 16'h3333);
		prog.wr(ADDR_CTRL, 16'h0005);
		fault(ERR_INSTR);
		prog.wr(ADDR_CTRL, 16'h0009);
		fault(ERR_INSTR);
		rc(DEST_BASE, 16'h1111);
		prog.wr(ADDR_STRLEN, 16'h0001);
		prog.wr(ADDR_CTRL, 16'h0001);
		rc(DEST_BASE, 16'h1133);
		rc(DEST_BASE + 8'h01, 16'ha022);
		for (int k = 0; k < 3; k++) begin
			prog.name(KIND_MON, MON_FIRST + 8'(k), 8'h41 + 8'(k));
			idle();
			chk(16'(monNameValid), 16'((1 << (k + 1)) - 1));
			for (int j = 0; j < 8; j++) begin
				rc(MON_BASE + 8'(8 * k + j), prog.chars(8'h41 + 8'(k), j));
			end
		end
		prog.name(KIND_MON, 8'h2b, 8'h5a);
		fault(ERR_OPER);
		prog.name(KIND_MON, 8'h27, 8'h5a);
		fault(ERR_OPER);
		prog.name(8'h05, MON_FIRST, 8'h5a);
		fault(ERR_OPER);
		rc(MON_BASE, prog.chars(8'h41, 0));
		prog.name(KIND_MON_CLR, 8'h29, 8'h5a);
		idle();
		chk(16'(monNameValid), 16'h0005);
		for (int k = 0; k < 5; k++) begin
			prog.name(KIND_ERRN, ERRN_FIRST + 8'(k), 8'h61 + 8'(k));
			rc(ERRN_BASE + 8'(8 * k + 7), prog.chars(8'h61 + 8'(k), 7));
		end
		chk(16'(errNameValid), 16'h001f);
		prog.name(KIND_ERRN, 8'h0f, 8'h7a);
		fault(ERR_OPER);
		prog.name(KIND_ERRN, 8'h15, 8'h7a);
		fault(ERR_OPER);
		prog.name(KIND_ERRN_CLR, 8'h12, 8'h7a);
		rc(ADDR_VALID, 16'h1b05);
		foreach (ue[i]) begin
			prog.wr(ADDR_USER_ERR, ue[i]);
			idle();
			chk(16'(userErrorActive), 16'(ue[i] >= 16'h0010 && ue[i] <= 16'h0014));
		end
		prog.wr(ADDR_IRQ_STAT, 16'h0005);
		prog.wr(ADDR_IRQ_MASK, 16'h0005);
		idle();
		chk(16'(irq), 16'h0000);
		rc(ADDR_IRQ_STAT, 16'h0002);
		prog.wr(ADDR_IRQ_MASK, 16'h0002);
		idle();
		chk(16'(irq), 16'h0001);
		prog.wr(ADDR_IRQ_STAT, 16'h0002);
		idle();
		chk(16'(irq), 16'h0000);
		rc(8'hf0, WORD_ZERO);
		rc(ADDR_CTRL, WORD_ZERO);
		end_sim();
	end
endmodule
